// [hdl/dcvw_regs.sv]
/*
 * Display cache detect and diagnostic register bank with legacy
 * VGA window steering. Assumes host strobes are synchronous, one
 * cycle each, to clock; reads return data one cycle after the strobe.
 */
// Notes on behaviour
// - Registers decode at I/O address and at same offset from memory base.
// - Index bits 3:0 pick the graphics register behind data port 3CFh.
// - Index register reads zero in bits 7:4.
// - Window control written at 3C2h, read at 3CCh, resets to zero.
// - Window enable clear blocks legacy window claim; set allows it.
// - Linear frame buffer outside legacy window ignores window enable.
// - Map mode bits 3:2 choose the legacy frame buffer range.
// - Map mode applies in VGA and non-linear extended modes.
// - Address mapping bit 4 sends paged access to VGA buffer or cache.
// - Address mapping bit 3 selects VGA buffer or memory map, resets 0.
// - Page mapping bit 0 maps through 64-KB A0000h window, resets off.
// - Page selector at index 11h picks the cache 64-KB window.
`timescale 1ns/1ns
module dcvw_regs (
    input  wire logic                clock,
    input  wire logic                sys_rst,
    input  wire logic                io_sel,
    input  wire logic [15:0]         io_addr,
    input  wire logic [31:0]         mem_addr,
    input  wire logic                wr_stb,
    input  wire logic                rd_stb,
    input  wire logic [7:0]          wr_data,
    input  wire logic [31:0]         graphics_memory_base,
    input  wire logic                linear_mode,
    input  wire logic [31:0]         cpu_addr,
    input  wire logic [31:0]         lfb_base,
    input  wire logic [31:0]         lfb_size,
    output logic [7:0]               rd_data,
    output logic                     rd_valid,
    output logic                     legacy_claim,
    output logic                     lfb_claim,
    output dcvw_pkg::dcvw_tgt_t      legacy_target,
    output logic [23:0]              cache_addr,
    output logic                     packed_en,
    output logic                     linear_en
);
    import dcvw_pkg::*;

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    logic        reg_hit;
    logic [15:0] reg_addr;
    dcvw_addr_dec u_addr_dec (
        .io_sel               (io_sel),
        .mem_addr             (mem_addr),
        .io_addr              (io_addr),
        .graphics_memory_base (graphics_memory_base),
        .reg_hit              (reg_hit),
        .reg_addr             (reg_addr)
    );

    logic [7:0] win_ctrl_q;
    logic [7:0] index_q;
    logic [7:0] map_mode_q;
    logic [7:0] addr_map_q;
    logic [7:0] page_sel_q;
    logic [7:0] rd_data_q;
    logic       rd_valid_q;

    wire at_wc_wr = reg_hit && reg_addr == DCVW_WIN_CTRL_WR_ADDR;
    wire at_wc_rd = reg_hit && reg_addr == DCVW_WIN_CTRL_RD_ADDR;
    wire at_index = reg_hit && reg_addr == DCVW_INDEX_ADDR;
    wire at_data  = reg_hit && reg_addr == DCVW_DATA_ADDR;
    wire sel_map  = at_data && index_q[3:0] == DCVW_IDX_MAP_MODE;
    wire sel_amap = at_data && index_q[3:0] == DCVW_IDX_ADDR_MAP[3:0];
    wire sel_page = at_data && index_q[3:0] == DCVW_IDX_PAGE_SEL[3:0];

    wire wr_wc   = wr_stb && at_wc_wr;
    wire wr_idx  = wr_stb && at_index;
    wire wr_map  = wr_stb && sel_map;
    wire wr_amap = wr_stb && sel_amap;
    wire wr_page = wr_stb && sel_page;

    // ------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            win_ctrl_q <= DCVW_WIN_CTRL_RST;
            index_q    <= DCVW_UNDEF_RST;
            map_mode_q <= DCVW_UNDEF_RST;
            addr_map_q <= DCVW_ADDR_MAP_RST;
            page_sel_q <= DCVW_UNDEF_RST;
        end else begin
            if (wr_wc)
                win_ctrl_q <= wr_data & DCVW_WIN_CTRL_MASK;
            if (wr_idx)
                index_q <= wr_data & DCVW_INDEX_MASK;
            if (wr_map)
                map_mode_q <= wr_data & DCVW_MAP_MODE_MASK;
            if (wr_amap)
                addr_map_q <= wr_data & DCVW_ADDR_MAP_MASK;
            if (wr_page)
                page_sel_q <= wr_data;
        end
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    wire [7:0] rd_mux = at_wc_rd ? win_ctrl_q :
                        at_index ? index_q :
                        sel_map  ? map_mode_q :
                        sel_amap ? addr_map_q :
                        sel_page ? page_sel_q : 8'h00;

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            rd_data_q  <= 8'h00;
            rd_valid_q <= 1'b0;
        end else begin
            rd_valid_q <= rd_stb;
            if (rd_stb)
                rd_data_q <= rd_mux;
        end
    end

    assign rd_data  = rd_data_q;
    assign rd_valid = rd_valid_q;

    // ------------------------------------------------------------
    // Window steering
    // ------------------------------------------------------------
    dcvw_ctrl_if ctrl ();
    assign ctrl.win_en        = win_ctrl_q[DCVW_WIN_EN_BIT];
    assign ctrl.map_mode      = dcvw_map_t'(
        map_mode_q[DCVW_MAP_LO_BIT+1:DCVW_MAP_LO_BIT]);
    assign ctrl.page_en       = addr_map_q[DCVW_PAGE_EN_BIT];
    assign ctrl.linear_en     = addr_map_q[DCVW_LINEAR_BIT];
    assign ctrl.packed_en     = addr_map_q[DCVW_PACKED_BIT];
    assign ctrl.memmap_sel    = addr_map_q[DCVW_MEMMAP_BIT];
    assign ctrl.page_to_cache = addr_map_q[DCVW_PG_CACHE_BIT];
    assign ctrl.page_sel      = page_sel_q;
    assign ctrl.linear_mode   = linear_mode;

    dcvw_win_dec u_win_dec (
        .ctrl       (ctrl),
        .cpu_addr   (cpu_addr),
        .claim      (legacy_claim),
        .target     (legacy_target),
        .cache_addr (cache_addr)
    );

    // Linear buffer claim independent of window enable
    wire [31:0] lfb_off = cpu_addr - lfb_base;
    assign lfb_claim = ctrl.linear_en && cpu_addr >= lfb_base &&
                       lfb_off < lfb_size;
    assign packed_en = ctrl.packed_en;
    assign linear_en = ctrl.linear_en;
endmodule // dcvw_regs

// [pkg/dcvw_pkg.sv]
/*
 * Package for the display cache VGA window register bank: register
 * addresses, graphics controller indices, field positions, reset values.
 * Assumes an 8-bit host I/O or memory-offset access port.
 */
package dcvw_pkg;

    // ------------------------------------------------------------
    // Addresses
    // ------------------------------------------------------------
    localparam logic [15:0] DCVW_WIN_CTRL_WR_ADDR = 16'h03c2;
    localparam logic [15:0] DCVW_WIN_CTRL_RD_ADDR = 16'h03cc;
    localparam logic [15:0] DCVW_INDEX_ADDR       = 16'h03ce;
    localparam logic [15:0] DCVW_DATA_ADDR        = 16'h03cf;
    localparam logic [15:0] DCVW_MMIO_SPAN        = 16'h0400;

    // ------------------------------------------------------------
    // Graphics controller indices
    // ------------------------------------------------------------
    localparam logic [3:0] DCVW_IDX_MAP_MODE = 4'h6;
    localparam logic [7:0] DCVW_IDX_ADDR_MAP = 8'h10;
    localparam logic [7:0] DCVW_IDX_PAGE_SEL = 8'h11;

    // ------------------------------------------------------------
    // Field masks and positions
    // ------------------------------------------------------------
    localparam logic [7:0] DCVW_INDEX_MASK    = 8'h0f;
    localparam logic [7:0] DCVW_WIN_CTRL_MASK = 8'h02;
    localparam logic [7:0] DCVW_MAP_MODE_MASK = 8'h0c;
    localparam logic [7:0] DCVW_ADDR_MAP_MASK = 8'h1f;
    localparam int DCVW_WIN_EN_BIT   = 1;
    localparam int DCVW_MAP_LO_BIT   = 2;
    localparam int DCVW_PAGE_EN_BIT  = 0;
    localparam int DCVW_LINEAR_BIT   = 1;
    localparam int DCVW_PACKED_BIT   = 2;
    localparam int DCVW_MEMMAP_BIT   = 3;
    localparam int DCVW_PG_CACHE_BIT = 4;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] DCVW_WIN_CTRL_RST = 8'h00;
    localparam logic [7:0] DCVW_ADDR_MAP_RST = 8'h00;
    localparam logic [7:0] DCVW_UNDEF_RST    = 8'h00;

    // ------------------------------------------------------------
    // Legacy window bounds (20-bit processor addresses)
    // ------------------------------------------------------------
    localparam logic [19:0] DCVW_A0000 = 20'ha0000;
    localparam logic [19:0] DCVW_AFFFF = 20'haffff;
    localparam logic [19:0] DCVW_B0000 = 20'hb0000;
    localparam logic [19:0] DCVW_B7FFF = 20'hb7fff;
    localparam logic [19:0] DCVW_B8000 = 20'hb8000;
    localparam logic [19:0] DCVW_BFFFF = 20'hbffff;

    typedef enum logic [1:0] {
        DCVW_MAP_128K = 2'b00,
        DCVW_MAP_A64K = 2'b01,
        DCVW_MAP_MONO = 2'b10,
        DCVW_MAP_COLR = 2'b11
    } dcvw_map_t;

    typedef enum logic [1:0] {
        DCVW_TGT_NONE  = 2'b00,
        DCVW_TGT_VGA   = 2'b01,
        DCVW_TGT_CACHE = 2'b10,
        DCVW_TGT_MMAP  = 2'b11
    } dcvw_tgt_t;

endpackage

// [pkg/dcvw_ctrl_if.sv]
/*
 * Interface carrying the decoded control fields from the register
 * bank to the window decoder. Assumes one clock domain.
 */
`timescale 1ns/1ns
interface dcvw_ctrl_if;
    import dcvw_pkg::*;
    logic      win_en;
    dcvw_map_t map_mode;
    logic      page_en;
    logic      linear_en;
    logic      packed_en;
    logic      memmap_sel;
    logic      page_to_cache;
    logic      linear_mode;
    logic [7:0] page_sel;

    modport regs (output win_en, map_mode, page_en, linear_en, packed_en,
                  memmap_sel, page_to_cache, page_sel, linear_mode);
    modport dec  (input win_en, map_mode, page_en, linear_en, packed_en,
                  memmap_sel, page_to_cache, page_sel, linear_mode);
endinterface

// [hdl/dcvw_addr_dec.sv]
/*
 * Host address decode: I/O hit or memory offset from the graphics
 * memory base. Assumes single-cycle strobed accesses.
 */
`timescale 1ns/1ns
module dcvw_addr_dec (
    input  wire logic        io_sel,
    input  wire logic [31:0] mem_addr,
    input  wire logic [15:0] io_addr,
    input  wire logic [31:0] graphics_memory_base,
    output logic             reg_hit,
    output logic [15:0]      reg_addr
);
    import dcvw_pkg::*;

    // ------------------------------------------------------------
    // Memory offset equals I/O address
    // ------------------------------------------------------------
    wire [31:0] mem_off = mem_addr - graphics_memory_base;
    wire        mem_hit = mem_addr >= graphics_memory_base &&
                          mem_off < {16'h0000, DCVW_MMIO_SPAN};

    assign reg_addr = io_sel ? io_addr : mem_off[15:0];
    assign reg_hit  = io_sel | mem_hit;
endmodule // dcvw_addr_dec

// [hdl/dcvw_win_dec.sv]
/*
 * Legacy window claim and target steering from the control fields.
 * Assumes 20-bit low processor address for the legacy range.
 */
`timescale 1ns/1ns
module dcvw_win_dec (
    dcvw_ctrl_if.dec          ctrl,
    input  wire logic [31:0]  cpu_addr,
    output logic              claim,
    output dcvw_pkg::dcvw_tgt_t target,
    output logic [23:0]       cache_addr
);
    import dcvw_pkg::*;

    // ------------------------------------------------------------
    // Map mode range select
    // ------------------------------------------------------------
    wire        low_mb = cpu_addr[31:20] == 12'h000;
    wire [19:0] a      = cpu_addr[19:0];
    wire in_128 = a >= DCVW_A0000 && a <= DCVW_BFFFF;
    wire in_a64 = a >= DCVW_A0000 && a < DCVW_B0000;
    wire in_mon = a >= DCVW_B0000 && a <= DCVW_B7FFF;
    wire in_col = a >= DCVW_B8000 && a <= DCVW_BFFFF;
    logic in_map;
    always_comb begin
        case (ctrl.map_mode)
            DCVW_MAP_128K: in_map = in_128;
            DCVW_MAP_A64K: in_map = in_a64;
            DCVW_MAP_MONO: in_map = in_mon;
            DCVW_MAP_COLR: in_map = in_col;
            default:       in_map = 1'b0;
        endcase
    end

    // Map mode only in modes without linear buffer access
    wire use_map = !ctrl.linear_mode;
    wire legacy  = low_mb && (use_map ? in_map : in_128);
    wire paged   = ctrl.page_en && low_mb && in_a64;

    assign claim = legacy && ctrl.win_en;
    assign target = !claim ? DCVW_TGT_NONE :
                    paged ? (ctrl.page_to_cache ? DCVW_TGT_CACHE
                                                : DCVW_TGT_VGA) :
                    ctrl.memmap_sel ? DCVW_TGT_MMAP
                                    : DCVW_TGT_VGA;
    assign cache_addr = {ctrl.page_sel, a[15:0]};
endmodule // dcvw_win_dec

// [verification/dcvw_regs_properties.sv]
/* Checker for the window register bank; bound to dcvw_regs by tb. */
`timescale 1ns/1ns
module dcvw_regs_props (
    input wire logic        clock,
    input wire logic        sys_rst,
    input wire logic        io_sel,
    input wire logic [15:0] io_addr,
    input wire logic [31:0] mem_addr,
    input wire logic        wr_stb,
    input wire logic        rd_stb,
    input wire logic [7:0]  wr_data,
    input wire logic [31:0] graphics_memory_base,
    input wire logic [31:0] cpu_addr,
    input wire logic [31:0] lfb_base,
    input wire logic [31:0] lfb_size,
    input wire logic [7:0]  rd_data,
    input wire logic        rd_valid,
    input wire logic        legacy_claim,
    input wire logic        lfb_claim,
    input wire logic [23:0] cache_addr,
    input wire logic        linear_en
);
    import dcvw_pkg::*;
    // ------------------------------
    // Window enable shadow
    // ------------------------------
    logic       win_q;
    wire [31:0] off = mem_addr - graphics_memory_base;
    wire        ix_hit = io_sel ? io_addr == 16'h03ce : off == 32'h3ce;
    wire        wr_hit = io_sel ? io_addr == 16'h03c2 : off == 32'h3c2;
    wire        rd_hit = io_sel ? io_addr == 16'h03cc : off == 32'h3cc;
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) win_q <= 1'b0;
        else if (wr_stb && wr_hit) win_q <= wr_data[DCVW_WIN_EN_BIT];
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);
    rd_cause_a: assert property (rd_valid |-> $past(rd_stb))
        else $error("read answer without a read");
    idx_read_a: assert property (rd_stb && ix_hit |=>
        rd_valid && rd_data[7:4] == 4'h0) else $error("index upper bits");
    win_read_a: assert property (rd_stb && rd_hit |=>
        rd_data == {6'h0, $past(win_q), 1'b0}) else $error("window readback");
    wr_port_a: assert property (rd_stb && wr_hit |=>
        rd_data == 8'h00) else $error("write port read not zero");
    claim_gate_a: assert property (legacy_claim |-> win_q)
        else $error("claim with window disabled");
    claim_range_a: assert property (legacy_claim |->
        cpu_addr[31:17] == 15'h0005) else $error("claim outside window");
    lfb_range_a: assert property (lfb_claim |-> linear_en &&
        cpu_addr >= lfb_base && cpu_addr - lfb_base < lfb_size)
        else $error("frame buffer claim outside range");
    cache_low_a: assert property (
        cache_addr[15:0] == cpu_addr[15:0]) else $error("cache offset");
endmodule // dcvw_regs_props

// [verification/dcvw_host_model.sv]
/* Host model: byte accesses, one per cycle; read data one cycle on. */
`timescale 1ns/1ns
module dcvw_host_model (
    input  wire logic        clock,
    input  wire logic [31:0] base,
    input  wire logic [7:0]  rd_data,
    output logic             io_sel,
    output logic [15:0]      io_addr,
    output logic [31:0]      mem_addr,
    output logic             wr_stb,
    output logic             rd_stb,
    output logic [7:0]       wr_data
);
    // ------------------------------
    // Access tasks
    // ------------------------------
    task automatic acc(input logic io, input logic [15:0] a, input logic wr,
                       input logic [7:0] d, output logic [7:0] q);
        io_sel = io;
        io_addr = a;
        mem_addr = base + {16'h0, a};
        wr_stb = wr;
        rd_stb = !wr;
        wr_data = d;
        @(posedge clock);
        #1;
        q = rd_data;
    endtask
    task automatic idle();
        wr_stb = 1'b0;
        rd_stb = 1'b0;
        io_addr = ~io_addr;
        mem_addr = ~mem_addr;
        wr_data = ~wr_data;
    endtask
    initial begin
        {io_sel, io_addr, mem_addr, wr_stb, rd_stb, wr_data} = '0;
    end
endmodule // dcvw_host_model

// [verification/tb.sv]
/* Top bench: host model and reference model around dcvw_regs. */
`timescale 1ns/1ns
`define CHK(n, e, g) begin checks++; if ((e) !== (g)) begin err_total++; \
    $display("BAD %s exp %h got %h", n, e, g); end end
module tb;
    import dcvw_pkg::*;
    logic        clock = 1'b0, sys_rst = 1'b1, linear_mode = 1'b0;
    logic [31:0] base = 32'h0, cpu_addr = 32'h0, lfb_base = 32'he0000000;
    logic [31:0] lfb_size = 32'h00100000, d, mem_addr;
    logic        io_sel, wr_stb, rd_stb, rd_valid, legacy_claim, lfb_claim;
    logic        packed_en, linear_en;
    logic [15:0] io_addr;
    logic [7:0]  wr_data, rd_data, q, m_win, m_idx, m_map, m_amap, m_psel;
    logic [23:0] cache_addr;
    dcvw_tgt_t   legacy_target;
    int          err_total = 0, checks = 0, seed = 32'hb44118c9;
    logic [7:0]  ix [4] = '{8'h16, 8'h10, 8'h11, 8'h02};
    logic [31:0] at [8] = '{32'h000a0000, 32'h000a8000, 32'h000b0000,
        32'h000b8000, 32'h000c0000, 32'h001a0000, 32'he0000000, 32'he00f8000};
    dcvw_regs dcvw_regs_i (.clock(clock), .sys_rst(sys_rst), .io_sel(io_sel),
        .io_addr(io_addr), .mem_addr(mem_addr), .wr_stb(wr_stb),
        .rd_stb(rd_stb), .wr_data(wr_data), .graphics_memory_base(base),
        .linear_mode(linear_mode), .cpu_addr(cpu_addr), .lfb_base(lfb_base),
        .lfb_size(lfb_size), .rd_data(rd_data), .rd_valid(rd_valid),
        .legacy_claim(legacy_claim), .lfb_claim(lfb_claim),
        .legacy_target(legacy_target), .cache_addr(cache_addr),
        .packed_en(packed_en), .linear_en(linear_en));
    dcvw_host_model dcvw_host_model_i (.clock(clock), .base(base),
        .rd_data(rd_data), .io_sel(io_sel), .io_addr(io_addr),
        .mem_addr(mem_addr), .wr_stb(wr_stb), .rd_stb(rd_stb),
        .wr_data(wr_data));
    always #50 clock = ~clock;
    // ------------------------------
    // Reference model and checks
    // ------------------------------
    function automatic logic [7:0] m_rd(logic [15:0] a);
        if (a == DCVW_WIN_CTRL_RD_ADDR) return m_win;
        if (a == DCVW_INDEX_ADDR) return m_idx;
        if (a != DCVW_DATA_ADDR) return 8'h00;
        return m_idx == 8'h06 ? m_map : m_idx == 8'h00 ? m_amap :
            m_idx == 8'h01 ? m_psel : 8'h00;
    endfunction
    task automatic op(logic io, logic [15:0] a, logic wr, logic [7:0] v);
        dcvw_host_model_i.acc(io, a, wr, v, q);
        `CHK("valid", !wr, rd_valid)
        if (!wr) `CHK("read", m_rd(a), q)
        else if (a == DCVW_WIN_CTRL_WR_ADDR) m_win = v & 8'h02;
        else if (a == DCVW_INDEX_ADDR) m_idx = v & 8'h0f;
        else if (a == DCVW_DATA_ADDR && m_idx == 8'h06) m_map = v & 8'h0c;
        else if (a == DCVW_DATA_ADDR && m_idx == 8'h00) m_amap = v & 8'h1f;
        else if (a == DCVW_DATA_ADDR && m_idx == 8'h01) m_psel = v;
    endtask
    task automatic claims(logic [31:0] a);
        logic [1:0] mm;
        logic       c;
        dcvw_tgt_t  t;
        cpu_addr = a;
        #1;
        mm = linear_mode ? 2'b00 : m_map[3:2];
        c = m_win[1] && a[31:20] == 12'h0 && (mm == 2'b00 ? a[19:17] == 3'h5
            : mm == 2'b01 ? a[19:16] == 4'ha : mm == 2'b10 ?
            a[19:15] == 5'h16 : a[19:15] == 5'h17);
        t = !c ? DCVW_TGT_NONE : (m_amap[0] && a[19:16] == 4'ha) ?
            (m_amap[4] ? DCVW_TGT_CACHE : DCVW_TGT_VGA) :
            m_amap[3] ? DCVW_TGT_MMAP : DCVW_TGT_VGA;
        `CHK("claim", c, legacy_claim)
        `CHK("lfb", m_amap[1] && a >= lfb_base && a - lfb_base < lfb_size,
            lfb_claim)
        `CHK("cache", {m_psel, a[15:0]}, cache_addr)
        `CHK("modes", m_amap[2:1], {packed_en, linear_en})
        `CHK("target", t, legacy_target)
    endtask
    task automatic chk_rst();
        {m_win, m_idx, m_map, m_amap, m_psel} = '0;
        op(1'b1, DCVW_WIN_CTRL_RD_ADDR, 1'b0, 8'h00);
        op(1'b0, DCVW_INDEX_ADDR, 1'b0, 8'h00);
        for (int k = 0; k < 3; k++) begin
            op(1'b1, DCVW_INDEX_ADDR, 1'b1, ix[k]);
            op(1'b0, DCVW_DATA_ADDR, 1'b0, 8'h00);
        end
        claims(32'h000a1234);
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        base = $random(seed) & 32'hfffff000;
        repeat (20) @(posedge clock);
        #1 sys_rst = 1'b0;
        chk_rst();
        $display("test 1 done");
        for (int i = 0; i < 24; i++) begin
            d = $random(seed);
            op(i[0], DCVW_INDEX_ADDR, 1'b1, {d[7:4], ix[i % 4][3:0]});
            op(!i[0], DCVW_DATA_ADDR, 1'b1, d[15:8]);
            op(i[0], DCVW_DATA_ADDR, 1'b0, 8'h00);
            op(i[0], DCVW_INDEX_ADDR, 1'b0, 8'h00);
            op(!i[0], DCVW_WIN_CTRL_WR_ADDR, 1'b1, d[23:16]);
            op(i[0], DCVW_WIN_CTRL_RD_ADDR, 1'b0, 8'h00);
            op(i[0], DCVW_WIN_CTRL_WR_ADDR, 1'b0, 8'h00);
            op(!i[0], DCVW_WIN_CTRL_RD_ADDR, 1'b1, d[31:24]);
            op(i[0], 16'h07ce, 1'b0, 8'h00);
        end
        $display("test 2 done");
        for (int i = 0; i < 64; i++) begin
            d = $random(seed);
            linear_mode = d[0];
            op(1'b1, DCVW_WIN_CTRL_WR_ADDR, 1'b1, {6'h0, d[1], 1'b0});
            op(1'b1, DCVW_INDEX_ADDR, 1'b1, 8'h06);
            op(1'b0, DCVW_DATA_ADDR, 1'b1, {4'h0, d[3:2], 2'h0});
            op(1'b1, DCVW_INDEX_ADDR, 1'b1, 8'h10);
            op(1'b0, DCVW_DATA_ADDR, 1'b1, {3'h0, d[8:4]});
            op(1'b1, DCVW_INDEX_ADDR, 1'b1, 8'h11);
            op(1'b1, DCVW_DATA_ADDR, 1'b1, d[23:16]);
            for (int j = 0; j < 8; j++) claims(at[j] | ($random(seed) & 'h7fff));
        end
        $display("test 3 done");
        dcvw_host_model_i.idle();
        sys_rst = 1'b1;
        repeat (3) @(posedge clock);
        #1 sys_rst = 1'b0;
        chk_rst();
        $display("test 4 done");
        summarize();
    end
    initial begin
        #2000000;
        err_total++;
        summarize();
    end
endmodule // tb
bind dcvw_regs dcvw_regs_props dcvw_regs_props_i (.clock(clock),
    .sys_rst(sys_rst), .io_sel(io_sel), .io_addr(io_addr),
    .mem_addr(mem_addr), .wr_stb(wr_stb), .rd_stb(rd_stb),
    .wr_data(wr_data), .graphics_memory_base(graphics_memory_base),
    .cpu_addr(cpu_addr), .lfb_base(lfb_base), .lfb_size(lfb_size),
    .rd_data(rd_data), .rd_valid(rd_valid), .legacy_claim(legacy_claim),
    .lfb_claim(lfb_claim), .cache_addr(cache_addr), .linear_en(linear_en));
